//--- core/rhc_defines.svh
/*
  timing and range constants for the rheostat wiper control.
  assumes a 250 MHz system clock; times are held in their own units and
  cycle counts are derived from them.
*/
`ifndef RHC_DEFINES_SVH
`define RHC_DEFINES_SVH

// clock period and the microsecond time base derived from it
`define RHC_CLK_PERIOD_PS   4000
`define RHC_US_PS           1000000
`define RHC_US_CYC          (`RHC_US_PS / `RHC_CLK_PERIOD_PS)

// pulse timing, in microseconds
`define RHC_CONTACT_MIN_US  1000
`define RHC_HOST_MIN_US     1
`define RHC_GAP_MIN_US      1000
`define RHC_HOLD_US         1000000
`define RHC_REPEAT_US       100000
`define RHC_IDLE_REV_US     1000000
`define RHC_STORE_DELAY_US  2000000

// wiper range
`define RHC_POS_W           6
`define RHC_POS_MIN         6'h00
`define RHC_POS_MAX         6'h3f
`define RHC_TIME_W          22

`endif

//--- core/rhc_pkg.sv
/*
  types shared by the rheostat wiper control files.
  assumes nothing beyond a SystemVerilog compiler.
*/
package rhc_pkg;
  // pulse qualifier state per control input
  typedef enum logic [1:0] {
    rhc_idle_s,
    rhc_low_s,
    rhc_gap_s
  } rhc_pstate_t;
endpackage

//--- core/rhc_pulse_timer.sv
/*
  pulse width qualifier for one active-low control input.
  assumes a synchronised input level and a one-cycle microsecond tick.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rhc_defines.svh"

module rhc_pulse_timer
  import rhc_pkg::*;
#(
  parameter int MIN_US    = `RHC_CONTACT_MIN_US,
  parameter int GAP_US    = `RHC_GAP_MIN_US,
  parameter int HOLD_US   = `RHC_HOLD_US,
  parameter int REPEAT_US = `RHC_REPEAT_US
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // time base and input level
  input  wire logic tick_us,
  input  wire logic level,
  // results
  output logic      step,
  output logic      active
);
  localparam logic [`RHC_TIME_W-1:0] MIN_T  = `RHC_TIME_W'(MIN_US);
  localparam logic [`RHC_TIME_W-1:0] GAP_T  = `RHC_TIME_W'(GAP_US);
  localparam logic [`RHC_TIME_W-1:0] HOLD_T = `RHC_TIME_W'(HOLD_US);
  localparam logic [`RHC_TIME_W-1:0] RPT_T  = `RHC_TIME_W'(REPEAT_US);

  rhc_pstate_t            state;
  logic [`RHC_TIME_W-1:0] low_cnt;
  logic [`RHC_TIME_W-1:0] gap_cnt;
  logic [`RHC_TIME_W-1:0] rpt_cnt;
  logic                   held;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state   <= rhc_idle_s;
      gap_cnt <= '0;
    end else begin
      case (state)
        rhc_idle_s: begin
          if (!level) state <= rhc_low_s;
        end
        rhc_low_s: begin
          gap_cnt <= '0;
          if (level) state <= rhc_gap_s;
        end
        rhc_gap_s: begin
          if (!level) begin
            state <= rhc_low_s;
          end else if (tick_us) begin
            gap_cnt <= gap_cnt + 1'b1;
            if (gap_cnt + 1'b1 >= GAP_T) state <= rhc_idle_s;
          end
        end
        default: state <= rhc_idle_s;
      endcase
    end
  end

  // low time accumulates across merged gaps; restarts only from idle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt <= '0;
      rpt_cnt <= '0;
      held    <= 1'b0;
      step    <= 1'b0;
    end else begin
      step <= 1'b0;
      if (state == rhc_idle_s) begin
        low_cnt <= '0;
        rpt_cnt <= '0;
        held    <= 1'b0;
      end else if (state == rhc_low_s && !level && tick_us) begin
        if (low_cnt != '1) low_cnt <= low_cnt + 1'b1;
        if (low_cnt == MIN_T) step <= 1'b1;
        if (held) begin
          rpt_cnt <= rpt_cnt + 1'b1;
          if (rpt_cnt + 1'b1 >= RPT_T) begin
            rpt_cnt <= '0;
            step    <= 1'b1;
          end
        end else if (low_cnt + 1'b1 >= HOLD_T) begin
          held <= 1'b1;
        end
      end
    end
  end

  assign active = (state != rhc_idle_s);
endmodule // rhc_pulse_timer

`default_nettype wire

//--- core/rhc_wiper_ctrl.sv
/*
  wiper position control of a 64-tap nonvolatile rheostat.
  assumes pins from outside the clock domain, a nonvolatile store that
  presents the saved position at reset and takes a one-cycle store strobe.
*/
// Function
// - each step moves the wiper exactly one tap of 64.
// - inputs idle high; a falling edge starts pulse timing.
// - contact low longer than 1 ms up to 1 s is one step.
// - host low longer than 1 us up to 1 s is one step.
// - gaps shorter than 1 ms merge pulses into one continuous pulse.
// - after the 1 s hold, step once every 100 ms while low.
// - single-button mode: up contact steps along the stored direction.
// - operating mode is latched from input state at power-up.
// - dual-button mode: up contact only raises, down contact only lowers.
// - host pulses move both ways using the single-button direction rule.
// - host pulses are accepted in every button configuration.
// - unconnected host input reads idle high and causes no movement.
// - integrated-button variant always runs single-button mode.
// - single and host control reverse direction at either range end.
// - single and host control reverse after one second of idle inputs.
// - dual mode stops at range ends until the opposite input.
// - restore saved position at power-up; store changes after 2 s.
`timescale 1ns/1ps
`default_nettype none
`include "rhc_defines.svh"

module rhc_wiper_ctrl
  import rhc_pkg::*;
#(
  parameter bit FIXED_SINGLE    = 1'b0,
  parameter int CONTACT_MIN_US  = `RHC_CONTACT_MIN_US,
  parameter int HOST_MIN_US     = `RHC_HOST_MIN_US,
  parameter int GAP_US          = `RHC_GAP_MIN_US,
  parameter int HOLD_US         = `RHC_HOLD_US,
  parameter int REPEAT_US       = `RHC_REPEAT_US,
  parameter int IDLE_REV_US     = `RHC_IDLE_REV_US,
  parameter int STORE_DELAY_US  = `RHC_STORE_DELAY_US
) (
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  nrst,
  // control pins, active low
  input  wire logic                  up_contact_pin,
  input  wire logic                  down_contact_pin,
  input  wire logic                  host_pulse_pin,
  // power-up mode sense: high when down contact is tied to supply
  input  wire logic                  single_strap,
  // nonvolatile store
  input  wire logic [`RHC_POS_W-1:0] saved_pos,
  output logic                       store_en,
  output logic [`RHC_POS_W-1:0]      store_pos,
  // wiper state
  output logic [`RHC_POS_W-1:0]      wiper_pos,
  output logic                       wiper_dir_up,
  output logic                       single_mode
);
  localparam logic [8:0] US_CYC = 9'(`RHC_US_CYC);
  localparam logic [`RHC_TIME_W-1:0] IDLE_T  = `RHC_TIME_W'(IDLE_REV_US);
  localparam logic [`RHC_TIME_W-1:0] STORE_T = `RHC_TIME_W'(STORE_DELAY_US);

  function automatic logic at_end(input logic [`RHC_POS_W-1:0] p);
    at_end = (p == `RHC_POS_MIN) || (p == `RHC_POS_MAX);
  endfunction

  // reset release
  logic [1:0] rst_sync;
  logic       rst_n;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) rst_sync <= 2'h0;
    else       rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // pin synchronisers; idle level is high
  logic [3:0] pin_s1;
  logic [3:0] pin_s2;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= 4'hf;
      pin_s2 <= 4'hf;
    end else begin
      pin_s1 <= {single_strap, host_pulse_pin, down_contact_pin,
                 up_contact_pin};
      pin_s2 <= pin_s1;
    end
  end

  // microsecond time base
  logic [8:0] div_cnt;
  logic       tick_us;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 9'h000;
      tick_us <= 1'b0;
    end else begin
      tick_us <= (div_cnt == US_CYC - 9'h001);
      div_cnt <= (div_cnt == US_CYC - 9'h001) ? 9'h000 : div_cnt + 9'h001;
    end
  end

  // power-up capture once synchronisers hold real pin levels
  logic [1:0] boot_cnt;
  logic       booted;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_cnt <= 2'h0;
      booted   <= 1'b0;
    end else if (boot_cnt != 2'h3) begin
      boot_cnt <= boot_cnt + 2'h1;
    end else begin
      booted <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      single_mode <= 1'b0;
    end else if (!booted && boot_cnt == 2'h3) begin
      single_mode <= FIXED_SINGLE | pin_s2[3];
    end
  end

  logic up_lvl, dn_lvl, host_lvl;
  assign up_lvl   = pin_s2[0] | ~booted;
  assign dn_lvl   = pin_s2[1] | ~booted | single_mode;
  assign host_lvl = pin_s2[2] | ~booted;

  logic up_step, dn_step, host_step;
  logic up_act, dn_act, host_act;

  rhc_pulse_timer #(
    .MIN_US    (CONTACT_MIN_US),
    .GAP_US    (GAP_US),
    .HOLD_US   (HOLD_US),
    .REPEAT_US (REPEAT_US)
  ) u_up (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .tick_us (tick_us),
    .level   (up_lvl),
    .step    (up_step),
    .active  (up_act)
  );

  rhc_pulse_timer #(
    .MIN_US    (CONTACT_MIN_US),
    .GAP_US    (GAP_US),
    .HOLD_US   (HOLD_US),
    .REPEAT_US (REPEAT_US)
  ) u_dn (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .tick_us (tick_us),
    .level   (dn_lvl),
    .step    (dn_step),
    .active  (dn_act)
  );

  rhc_pulse_timer #(
    .MIN_US    (HOST_MIN_US),
    .GAP_US    (GAP_US),
    .HOLD_US   (HOLD_US),
    .REPEAT_US (REPEAT_US)
  ) u_host (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .tick_us (tick_us),
    .level   (host_lvl),
    .step    (host_step),
    .active  (host_act)
  );

  // direction-following step: host always, up contact in single mode
  logic dir_step;
  assign dir_step = host_step | (single_mode & up_step);

  // idle timer for direction reversal
  logic [`RHC_TIME_W-1:0] idle_cnt;
  logic                   idle_flip;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_cnt  <= '0;
      idle_flip <= 1'b0;
    end else begin
      idle_flip <= 1'b0;
      if (up_act || host_act) begin
        idle_cnt <= '0;
      end else if (tick_us && idle_cnt != IDLE_T) begin
        idle_cnt <= idle_cnt + 1'b1;
        if (idle_cnt + 1'b1 == IDLE_T) idle_flip <= 1'b1;
      end
    end
  end

  // wiper position and direction; one move per cycle, host first
  logic [`RHC_POS_W-1:0] next_pos;
  always_comb begin
    next_pos = wiper_pos;
    if (dir_step) begin
      if (wiper_dir_up && wiper_pos != `RHC_POS_MAX)
        next_pos = wiper_pos + 1'b1;
      else if (!wiper_dir_up && wiper_pos != `RHC_POS_MIN)
        next_pos = wiper_pos - 1'b1;
    end else if (!single_mode && up_step) begin
      if (wiper_pos != `RHC_POS_MAX) next_pos = wiper_pos + 1'b1;
    end else if (!single_mode && dn_step) begin
      if (wiper_pos != `RHC_POS_MIN) next_pos = wiper_pos - 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wiper_pos <= `RHC_POS_MIN;
    end else if (!booted) begin
      wiper_pos <= saved_pos;
    end else begin
      wiper_pos <= next_pos;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wiper_dir_up <= 1'b1;
    end else if (!booted) begin
      // start upward unless the restored position is the top end
      wiper_dir_up <= (saved_pos != `RHC_POS_MAX);
    end else if (dir_step && at_end(next_pos) && next_pos != wiper_pos) begin
      wiper_dir_up <= (next_pos == `RHC_POS_MIN);
    end else if (dir_step && at_end(wiper_pos)) begin
      // stuck at an end with flag pointing outward
      wiper_dir_up <= (wiper_pos == `RHC_POS_MIN);
    end else if (idle_flip) begin
      wiper_dir_up <= ~wiper_dir_up;
    end
  end

  // delayed store; a new move restarts the delay to spare write cycles
  logic [`RHC_TIME_W-1:0] store_cnt;
  logic                   store_pend;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      store_cnt  <= '0;
      store_pend <= 1'b0;
      store_en   <= 1'b0;
      store_pos  <= `RHC_POS_MIN;
    end else begin
      store_en <= 1'b0;
      if (booted && next_pos != wiper_pos) begin
        store_pend <= 1'b1;
        store_cnt  <= '0;
      end else if (store_pend && tick_us) begin
        store_cnt <= store_cnt + 1'b1;
        if (store_cnt + 1'b1 >= STORE_T) begin
          store_pend <= 1'b0;
          store_en   <= 1'b1;
          store_pos  <= wiper_pos;
        end
      end
    end
  end
endmodule // rhc_wiper_ctrl

`default_nettype wire

//--- test/rhc_wiper_ctrl_assertions.sv
/*
  concurrent checks on the wiper control top ports.
  assumes one clock domain and pins that idle high between pulses.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rhc_defines.svh"

module rhc_wiper_ctrl_chk (
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  nrst,
  // control pins and strap
  input  wire logic                  up_contact_pin,
  input  wire logic                  down_contact_pin,
  input  wire logic                  host_pulse_pin,
  input  wire logic                  single_strap,
  // store and wiper
  input  wire logic [`RHC_POS_W-1:0] saved_pos,
  input  wire logic                  store_en,
  input  wire logic [`RHC_POS_W-1:0] store_pos,
  input  wire logic [`RHC_POS_W-1:0] wiper_pos,
  input  wire logic                  wiper_dir_up,
  input  wire logic                  single_mode
);
  logic [3:0] run;
  logic [4:0] hu;
  logic [4:0] hd;
  logic [4:0] hh;
  logic       live;
  logic       qu;
  logic       qd;
  logic       qh;

  // boot window loads saved_pos freely, so checks wait it out
  assign live = (run == 4'hf);
  // more than 16 cycles high covers sync flops plus step latency
  assign qu = (hu > 5'h10);
  assign qd = (hd > 5'h10);
  assign qh = (hh > 5'h10);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) run <= 4'h0;
    else if (!live) run <= run + 4'h1;
  end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) hu <= 5'h00;
    else if (!up_contact_pin) hu <= 5'h00;
    else if (hu != 5'h1f) hu <= hu + 5'h01;
  end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) hd <= 5'h00;
    else if (!down_contact_pin) hd <= 5'h00;
    else if (hd != 5'h1f) hd <= hd + 5'h01;
  end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) hh <= 5'h00;
    else if (!host_pulse_pin) hh <= 5'h00;
    else if (hh != 5'h1f) hh <= hh + 5'h01;
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  a_step_one_tap: assert property (live && $changed(wiper_pos) |->
    ({1'b0, wiper_pos} == {1'b0, $past(wiper_pos)} + 7'h01) ||
    ({1'b0, $past(wiper_pos)} == {1'b0, wiper_pos} + 7'h01))
    else $error("wiper moved other than one tap");
  a_store_pulse_one: assert property (store_en |=> !store_en)
    else $error("store strobe longer than one cycle");
  a_store_value: assert property (store_en |-> store_pos == wiper_pos)
    else $error("stored value differs from wiper");
  a_mode_stable: assert property (live |-> $stable(single_mode))
    else $error("mode changed after power-up");
  a_idle_no_move: assert property (live && qu && qd && qh |->
    $stable(wiper_pos))
    else $error("wiper moved with all pins idle");
  a_dual_up_only: assert property (live && !single_mode && qd && qh &&
    $changed(wiper_pos) |-> wiper_pos > $past(wiper_pos))
    else $error("up contact lowered wiper in dual mode");
  a_dual_down_only: assert property (live && !single_mode && qu && qh &&
    $changed(wiper_pos) |-> wiper_pos < $past(wiper_pos))
    else $error("down contact raised wiper in dual mode");
  a_dir_at_top: assert property (live && single_mode &&
    $changed(wiper_pos) && wiper_pos == `RHC_POS_MAX |-> ##[0:2] !wiper_dir_up)
    else $error("direction not reversed at top end");
endmodule // rhc_wiper_ctrl_chk

bind rhc_wiper_ctrl rhc_wiper_ctrl_chk chk_u (
  .sys_clk(sys_clk), .nrst(nrst), .up_contact_pin(up_contact_pin),
  .down_contact_pin(down_contact_pin), .host_pulse_pin(host_pulse_pin),
  .single_strap(single_strap), .saved_pos(saved_pos), .store_en(store_en),
  .store_pos(store_pos), .wiper_pos(wiper_pos),
  .wiper_dir_up(wiper_dir_up), .single_mode(single_mode));
`default_nettype wire

//--- test/rhc_buttons.sv
/*
  pushbuttons and host pulse source facing the wiper control.
  assumes the bench calls press() one pulse at a time.
*/
`timescale 1ns/1ps
`default_nettype none

module rhc_buttons (
  // clock
  input  wire logic sys_clk,
  // control pins, low while pressed
  output wire logic up_contact_pin,
  output wire logic down_contact_pin,
  output wire logic host_pulse_pin
);
  logic [2:0] p = 3'h7;
  assign up_contact_pin   = p[0];
  assign down_contact_pin = p[1];
  assign host_pulse_pin   = p[2];

  task automatic press(input int pin, input int lo_us, input int hi_us);
    @(negedge sys_clk);
    p[pin] = 1'b0;
    repeat (lo_us * 250) @(negedge sys_clk);
    p[pin] = 1'b1;
    repeat (hi_us * 250) @(negedge sys_clk);
  endtask
endmodule // rhc_buttons
`default_nettype wire

//--- test/rhc_wiper_ctrl_tb.sv
/*
  self-checking bench for the wiper control, times shortened.
  assumes the button model drives the pins; 1 us is 250 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rhc_defines.svh"

module rhc_wiper_ctrl_tb #(
  // shortened times in microseconds; the tick stays 250 cycles
  parameter int T_MIN   = 3,
  parameter int T_GAP   = 3,
  parameter int T_HOLD  = 20,
  parameter int T_RPT   = 5,
  parameter int T_IDLE  = 30,
  parameter int T_STORE = 40
);
  logic                  sys_clk = 1'b0;
  logic                  nrst;
  logic                  single_strap;
  logic [`RHC_POS_W-1:0] saved_pos;
  logic [`RHC_POS_W-1:0] exp;
  wire logic             up_c;
  wire logic             dn_c;
  wire logic             ho_c;
  logic                  store_en;
  logic [`RHC_POS_W-1:0] store_pos;
  logic [`RHC_POS_W-1:0] wiper_pos;
  logic                  wiper_dir_up;
  logic                  single_mode;
  int                    mismatches;
  int                    compares;
  int                    i;

  always #2 sys_clk = ~sys_clk;

  rhc_buttons bt (.sys_clk(sys_clk), .up_contact_pin(up_c),
    .down_contact_pin(dn_c), .host_pulse_pin(ho_c));

  rhc_wiper_ctrl #(.CONTACT_MIN_US(T_MIN), .GAP_US(T_GAP), .HOLD_US(T_HOLD),
    .REPEAT_US(T_RPT), .IDLE_REV_US(T_IDLE), .STORE_DELAY_US(T_STORE)) dut_u (
    .sys_clk(sys_clk), .nrst(nrst), .up_contact_pin(up_c),
    .down_contact_pin(dn_c), .host_pulse_pin(ho_c),
    .single_strap(single_strap), .saved_pos(saved_pos),
    .store_en(store_en), .store_pos(store_pos), .wiper_pos(wiper_pos),
    .wiper_dir_up(wiper_dir_up), .single_mode(single_mode));

  function automatic logic [5:0] nxt(input logic [5:0] p, input logic up);
    if (up) return (p == 6'h3f) ? p : p + 6'h01;
    return (p == 6'h00) ? p : p - 6'h01;
  endfunction

  task automatic check(input logic [5:0] got, input logic [5:0] want);
    compares++;
    if (got !== want) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask

  task automatic boot(input logic s, input logic [5:0] pos);
    @(negedge sys_clk);
    nrst = 1'b0;
    single_strap = s;
    saved_pos = pos;
    repeat (4) @(negedge sys_clk);
    nrst = 1'b1;
    repeat (12) @(negedge sys_clk);
    exp = pos;
  endtask

  task automatic give_verdict;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // about 70k cycles of tests; cut off past that
  initial begin
    #400000;
    mismatches++;
    give_verdict();
  end

  initial begin
    nrst = 1'b0;
    single_strap = 1'b0;
    saved_pos = 6'h00;
    mismatches = 0;
    compares = 0;
    void'($urandom(88103));
    boot(1'b0, 6'h3d);
    check(wiper_pos, exp);
    check({5'h00, single_mode}, 6'h00);
    // three ticks low so two whole ticks count at any tick phase
    bt.press(2, 3, 5);
    exp = nxt(exp, 1'b1);
    check(wiper_pos, exp);
    bt.press(0, 6, 5);
    exp = nxt(exp, 1'b1);
    check(wiper_pos, exp);
    bt.press(0, 6, 5);
    check(wiper_pos, exp);
    bt.press(1, 2, 5);
    check(wiper_pos, exp);
    bt.press(1, 3, 1);
    bt.press(1, 3, 5);
    exp = nxt(exp, 1'b0);
    check(wiper_pos, exp);
    bt.press(1, 27, 5);
    exp = nxt(nxt(exp, 1'b0), 1'b0);
    check(wiper_pos, exp);
    for (i = 0; i < 6; i++) begin
      if ($urandom % 2) begin
        bt.press(0, 5 + $urandom % 10, 4 + $urandom % 4);
        exp = nxt(exp, 1'b1);
      end else begin
        bt.press(1, 5 + $urandom % 10, 4 + $urandom % 4);
        exp = nxt(exp, 1'b0);
      end
      check(wiper_pos, exp);
    end
    for (i = 0; i < (T_STORE + 10) * 250 && store_en !== 1'b1; i++)
      @(negedge sys_clk);
    check({5'h00, store_en}, 6'h01);
    check(store_pos, exp);
    boot(1'b1, 6'h3e);
    check({5'h00, single_mode}, 6'h01);
    check(wiper_pos, exp);
    bt.press(0, 6, 5);
    exp = nxt(exp, 1'b1);
    check(wiper_pos, exp);
    check({5'h00, wiper_dir_up}, 6'h00);
    bt.press(0, 6, 5);
    exp = nxt(exp, 1'b0);
    check(wiper_pos, exp);
    bt.press(1, 6, 5);
    check(wiper_pos, exp);
    bt.press(2, 3, 35);
    exp = nxt(exp, 1'b0);
    check(wiper_pos, exp);
    check({5'h00, wiper_dir_up}, 6'h01);
    bt.press(0, 6, 5);
    exp = nxt(exp, 1'b1);
    check(wiper_pos, exp);
    give_verdict();
  end
endmodule // rhc_wiper_ctrl_tb
`default_nettype wire
